// ==== logic/rfq_pkg.sv ====
// rfq_pkg: register offsets, field positions and reset values for the
// per-port frame qualifier.
// assumes: 8-bit register window reached through a port-select register.
package rfq_pkg;
   localparam int          NUM_PORTS      = 2;
   localparam logic [7:0]  ADDR_PORT_SEL  = 8'h4C;
   localparam logic [7:0]  ADDR_CHECK_CFG = 8'h7C;
   localparam logic [7:0]  ADDR_QUAL_CTL  = 8'h7D;
   localparam logic [7:0]  CHECK_CFG_RST  = 8'h20;
   localparam logic [7:0]  QUAL_CTL_RST   = 8'h00;
   localparam logic [7:0]  PORT_SEL_RST   = 8'h00;
   // check config fields
   localparam int          CC_PACK_HI     = 7;
   localparam int          CC_PACK_LO     = 6;
   localparam int          CC_TRUNC_PAR   = 5;
   localparam int          CC_TRUNC_LSIZE = 4;
   localparam int          CC_TRUNC_FSIZE = 3;
   localparam int          CC_LINE_LEVEL  = 1;
   localparam int          CC_FRAME_LEVEL = 0;
   // qualify control fields
   localparam int          QC_DISCARD_EN  = 7;
   localparam int          QC_LINE_COUNT  = 5;
   localparam int          QC_LINE_SIZE   = 4;
   localparam int          QC_PAR_STICKY  = 3;
   localparam int          QC_WDOG_OFF    = 2;
   localparam int          QC_THR_HI      = 1;
   localparam int          QC_THR_LO      = 0;
   // packing codes
   localparam logic [1:0]  PACK_NORMAL    = 2'h0;
   localparam logic [1:0]  PACK_UPPER     = 2'h2;
   localparam logic [1:0]  PACK_LOWER     = 2'h3;
   // watchdog frame-period counter width
   localparam int          PERIOD_W       = 24;
   localparam int          WDOG_PERIODS   = 2;
endpackage : rfq_pkg

// ==== logic/rfq_cfg_if.sv ====
// rfq_cfg_if: per-port configuration fields from the register file to a
// port qualifier.
// assumes: one instance per receive port, same clock on both sides.
interface rfq_cfg_if;
   logic [7:0] check_cfg;
   logic [7:0] qual_ctl;
   modport regs (output check_cfg, output qual_ctl);
   modport port (input  check_cfg, input  qual_ctl);
endinterface : rfq_cfg_if

// ==== logic/rfq_port_qual.sv ====
// rfq_port_qual: qualification and forwarding control for one port.
// assumes: link-side event inputs are already synchronous to i_sys_clk.
module rfq_port_qual
(
   input  wire logic  i_sys_clk,
   input  wire logic  i_rst_n,
   rfq_cfg_if.port    cfg,
   input  wire logic  i_lock,
   input  wire logic  i_frame_raw,
   input  wire logic  i_line_raw,
   input  wire logic  i_pix_vld,
   input  wire logic [9:0] i_pix,
   input  wire logic  i_par_err,
   output logic       o_qualified,
   output logic       o_fwd_vld,
   output logic [9:0] o_fwd_pix
);
   logic                        frame_act, line_act, frame_q, line_q;
   logic                        frame_end, frame_start, line_end;
   logic [15:0]                 line_len, line_len_ref, line_cnt, lines_ref;
   logic                        len_known, cnt_known, trunc;
   logic                        lsize_chg, lcnt_chg;
   logic [1:0]                  good_cnt, thr;
   logic [rfq_pkg::PERIOD_W-1:0] period, wdog;
   logic                        frame_bad, wdog_hit, qual_drop;

   // polarity: level 1 means the flag is low while active
   assign frame_act = i_frame_raw ^ cfg.check_cfg[rfq_pkg::CC_FRAME_LEVEL]; // [RQ7]
   assign line_act  = i_line_raw ^ cfg.check_cfg[rfq_pkg::CC_LINE_LEVEL]; // [RQ6]
   assign frame_end   = frame_q & ~frame_act;
   assign frame_start = ~frame_q & frame_act;
   assign line_end    = line_q & ~line_act;
   assign thr         = cfg.qual_ctl[rfq_pkg::QC_THR_HI:rfq_pkg::QC_THR_LO];
   assign lsize_chg   = line_end & len_known & (line_len != line_len_ref);
   assign lcnt_chg    = frame_end & cnt_known & (line_cnt != lines_ref);
   // watchdog: no frame end within two measured frame periods
   assign wdog_hit = ~cfg.qual_ctl[rfq_pkg::QC_WDOG_OFF] && thr != 2'h0
                     && period != '0
                     && wdog >= period * rfq_pkg::WDOG_PERIODS; // [RQ13]
   assign qual_drop = ~i_lock                                          // [RQ16]
      | (cfg.qual_ctl[rfq_pkg::QC_LINE_COUNT] & lcnt_chg)              // [RQ9]
      | (cfg.qual_ctl[rfq_pkg::QC_LINE_SIZE] & lsize_chg)              // [RQ10]
      | i_par_err                                                      // [RQ11]
      | wdog_hit;

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
      if (!i_rst_n)
      begin
         frame_q <= 1'b0;
         line_q  <= 1'b0;
      end
      else
      begin
         frame_q <= frame_act;
         line_q  <= line_act;
      end

   // line size and line count references
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
      if (!i_rst_n)
      begin
         line_len <= '0;
         line_len_ref <= '0;
         len_known <= 1'b0;
         line_cnt <= '0;
         lines_ref <= '0;
         cnt_known <= 1'b0;
      end
      else
      begin
         if (line_end)
         begin
            line_len     <= '0;
            line_len_ref <= line_len;
            len_known    <= 1'b1;
         end
         else if (line_act && i_pix_vld)
            line_len <= line_len + 16'h0001;
         if (frame_end)
         begin
            line_cnt  <= '0;
            lines_ref <= line_cnt;
            cnt_known <= 1'b1;
         end
         else if (line_end)
            line_cnt <= line_cnt + 16'h0001;
      end

   // frame period measure and watchdog counter
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
      if (!i_rst_n)
      begin
         period <= '0;
         wdog   <= '0;
      end
      else if (!i_lock)
      begin
         // saturated count wraps the first period after lock to zero, so a
         // partial frame never arms the watchdog with a short period
         period <= '0;
         wdog   <= '1;
      end
      else if (frame_end)
      begin
         period <= wdog + 1'b1;
         wdog   <= '0;
      end
      else if (wdog != '1)
         wdog <= wdog + 1'b1;

   // errored frame tracking: a frame counts as valid only if clean
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
      if (!i_rst_n)
         frame_bad <= 1'b0;
      else if (frame_start)
         frame_bad <= i_par_err | lsize_chg;
      else if (i_par_err || lsize_chg)
         frame_bad <= 1'b1;

   // valid-frame count and qualified indication
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
      if (!i_rst_n)
      begin
         good_cnt    <= '0;
         o_qualified <= 1'b0;
      end
      else if (qual_drop)
      begin
         o_qualified <= 1'b0;
         // non-sticky parity drop keeps the count so pass returns at once
         if (!(i_par_err && i_lock && !cfg.qual_ctl[rfq_pkg::QC_PAR_STICKY]
               && !lcnt_chg && !lsize_chg && !wdog_hit))
            good_cnt <= '0; // [RQ16] [RQ11]
      end
      else if (thr == 2'h0)
         o_qualified <= 1'b1; // [RQ14]
      else if (good_cnt >= thr)
         o_qualified <= 1'b1; // [RQ14]
      else if (frame_end && !frame_bad && !lcnt_chg)
      begin
         good_cnt    <= good_cnt + 2'h1;
         o_qualified <= (good_cnt + 2'h1) >= thr; // [RQ14] [RQ5]
      end

   ////////////////////////////////////////////////////////////////////////
   // frame truncation: held until the next frame start; an error seen in
   // the start cycle itself still truncates
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
      if (!i_rst_n)
         trunc <= 1'b0;
      else
         trunc <= (trunc & ~frame_start)
            | (cfg.check_cfg[rfq_pkg::CC_TRUNC_PAR] & i_par_err)    // [RQ3]
            | (cfg.check_cfg[rfq_pkg::CC_TRUNC_LSIZE] & lsize_chg)  // [RQ4]
            | (cfg.check_cfg[rfq_pkg::CC_TRUNC_FSIZE] & lcnt_chg);  // [RQ5]

   // forwarding with packing select
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
      if (!i_rst_n)
      begin
         o_fwd_vld <= 1'b0;
         o_fwd_pix <= '0;
      end
      else
      begin
         o_fwd_vld <= i_pix_vld & frame_act & line_act & ~trunc
                    & ~(cfg.qual_ctl[rfq_pkg::QC_DISCARD_EN]
                        & ~o_qualified); // [RQ8]
         unique case (cfg.check_cfg[rfq_pkg::CC_PACK_HI:rfq_pkg::CC_PACK_LO])
            rfq_pkg::PACK_UPPER: o_fwd_pix <= {2'h0, i_pix[9:2]}; // [RQ1]
            rfq_pkg::PACK_LOWER: o_fwd_pix <= {2'h0, i_pix[7:0]}; // [RQ1]
            default:             o_fwd_pix <= i_pix; // [RQ1]
         endcase
      end
endmodule : rfq_port_qual

// ==== logic/rfq_top.sv ====
// rfq_top: per-port frame qualifier with port-selected register window.
// assumes: byte register access strobes from an I2C target on i_sys_clk;
// link inputs come from another domain and are synchronised here.

// Summary of operation
// RQ1: pack select picks normal, upper or lower bits
// RQ2: software updates raw data type when packing
// RQ3: parity truncation bit, default set
// RQ4: line size change truncates frame when enabled
// RQ5: line count change truncates; resume after threshold
// RQ6: line flag polarity chosen by bit one
// RQ7: frame flag polarity chosen by bit zero
// RQ8: discard packets while unqualified when enabled
// RQ9: line count change drops qualified until threshold
// RQ10: line size change drops qualified until threshold
// RQ11: parity drops qualified, sticky mode until threshold
// RQ12: software uses threshold two with sticky parity
// RQ13: watchdog drops qualified after two frame periods
// RQ14: threshold zero means lock, else frame count
// RQ15: registers per port, chosen by port select
// RQ16: no lock holds unqualified; count restarts
module rfq_top
(
   input  wire logic                      i_sys_clk,
   input  wire logic                      i_rst_n,
   input  wire logic                      i_reg_wr,
   input  wire logic                      i_reg_rd,
   input  wire logic [7:0]                i_reg_addr,
   input  wire logic [7:0]                i_reg_wdata,
   output logic      [7:0]                o_reg_rdata,
   input  wire logic [rfq_pkg::NUM_PORTS-1:0] i_lock,
   input  wire logic [rfq_pkg::NUM_PORTS-1:0] i_frame_active_flag,
   input  wire logic [rfq_pkg::NUM_PORTS-1:0] i_line_active_flag,
   input  wire logic [rfq_pkg::NUM_PORTS-1:0] i_pix_vld,
   input  wire logic [rfq_pkg::NUM_PORTS*10-1:0] i_pix,
   input  wire logic [rfq_pkg::NUM_PORTS-1:0] i_par_err,
   output logic      [rfq_pkg::NUM_PORTS-1:0] o_qualified,
   output logic      [rfq_pkg::NUM_PORTS-1:0] o_fwd_vld,
   output logic      [rfq_pkg::NUM_PORTS*10-1:0] o_fwd_pix
);
   localparam int NP = rfq_pkg::NUM_PORTS;
   logic [7:0] port_sel;
   logic [7:0] check_cfg [NP];
   logic [7:0] qual_ctl  [NP];
   logic [NP-1:0] qual_w, fvld_w;
   logic [NP*10-1:0] fpix_w;

   ////////////////////////////////////////////////////////////////////////
   // port select: bits 0 and 1 enable writes to the copy of port 0 and port 1
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
      if (!i_rst_n)
         port_sel <= rfq_pkg::PORT_SEL_RST;
      else if (i_reg_wr && i_reg_addr == rfq_pkg::ADDR_PORT_SEL)
         port_sel <= i_reg_wdata;

   // reads come from port 0 when its write bit is set, otherwise from port 1
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
      if (!i_rst_n)
         o_reg_rdata <= '0;
      else if (i_reg_rd)
      begin
         unique case (i_reg_addr)
            rfq_pkg::ADDR_PORT_SEL:  o_reg_rdata <= port_sel;
            rfq_pkg::ADDR_CHECK_CFG: o_reg_rdata <= check_cfg[port_sel[0] ? 0 : 1]; // [RQ15]
            rfq_pkg::ADDR_QUAL_CTL:  o_reg_rdata <= qual_ctl[port_sel[0] ? 0 : 1]; // [RQ15]
            default:                 o_reg_rdata <= '0;
         endcase
      end

   ////////////////////////////////////////////////////////////////////////
   genvar p;
   generate
      for (p = 0; p < NP; p++)
      begin : g_port
         rfq_cfg_if cfg_i ();
         logic [4:0] s1, s2;
         logic [9:0] pix1, pix2;

         always_ff @(posedge i_sys_clk or negedge i_rst_n)
            if (!i_rst_n)
            begin
               check_cfg[p] <= rfq_pkg::CHECK_CFG_RST;
               qual_ctl[p]  <= rfq_pkg::QUAL_CTL_RST;
            end
            else if (i_reg_wr && port_sel[p])
            begin
               if (i_reg_addr == rfq_pkg::ADDR_CHECK_CFG)
                  check_cfg[p] <= i_reg_wdata; // [RQ15]
               if (i_reg_addr == rfq_pkg::ADDR_QUAL_CTL)
                  qual_ctl[p] <= i_reg_wdata; // [RQ15]
            end

         assign cfg_i.check_cfg = check_cfg[p];
         assign cfg_i.qual_ctl  = qual_ctl[p];

         // two-flop synchronisers on the link-side inputs
         always_ff @(posedge i_sys_clk or negedge i_rst_n)
            if (!i_rst_n)
            begin
               s1 <= '0;
               s2 <= '0;
               pix1 <= '0;
               pix2 <= '0;
            end
            else
            begin
               s1 <= {i_lock[p], i_frame_active_flag[p],
                      i_line_active_flag[p], i_pix_vld[p], i_par_err[p]};
               s2 <= s1;
               pix1 <= i_pix[p*10 +: 10];
               pix2 <= pix1;
            end

         rfq_port_qual u_qual
         (
            .i_sys_clk   (i_sys_clk),
            .i_rst_n     (i_rst_n),
            .cfg         (cfg_i.port),
            .i_lock      (s2[4]),
            .i_frame_raw (s2[3]),
            .i_line_raw  (s2[2]),
            .i_pix_vld   (s2[1]),
            .i_pix       (pix2),
            .i_par_err   (s2[0]),
            .o_qualified (qual_w[p]),
            .o_fwd_vld   (fvld_w[p]),
            .o_fwd_pix   (fpix_w[p*10 +: 10])
         );
      end
   endgenerate

   assign o_qualified = qual_w;
   assign o_fwd_vld   = fvld_w;
   assign o_fwd_pix   = fpix_w;
endmodule : rfq_top

// ==== dv/rfq_asserts.sv ====
// rfq_asserts: pin-level checks of port 0 and of register reads of the frame qualifier.
// assumes: bound to rfq_top; port-0 config mirrored from register writes.
module rfq_asserts
(
   input wire logic        i_sys_clk,
   input wire logic        i_rst_n,
   input wire logic        i_reg_wr,
   input wire logic        i_reg_rd,
   input wire logic [7:0]  i_reg_addr,
   input wire logic [7:0]  i_reg_wdata,
   input wire logic [7:0]  o_reg_rdata,
   input wire logic [1:0]  i_lock,
   input wire logic [19:0] i_pix,
   input wire logic [1:0]  i_par_err,
   input wire logic [1:0]  o_qualified,
   input wire logic [1:0]  o_fwd_vld,
   input wire logic [19:0] o_fwd_pix
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] psel, cc0, qc0;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   ////////////////////////////////////////////////////////////////////////////
   // mirror of port-0 config, updated on the same edge as the register file
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         {psel, cc0, qc0} <= {8'h00, 8'h20, 8'h00};
      else if (i_reg_wr)
      begin
         if (i_reg_addr == 8'h4C)
            psel <= i_reg_wdata;
         if (i_reg_addr == 8'h7C && psel[0])
            cc0 <= i_reg_wdata;
         if (i_reg_addr == 8'h7D && psel[0])
            qc0 <= i_reg_wdata;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   property p_nolock;
      (!i_lock[0]) [*4] |-> !o_qualified[0];
   endproperty
   a_nolock: assert property (p_nolock)
      else $error("qualified without lock");
   // six clean cycles cover the two-flop sync plus the output register
   property p_thr0;
      (qc0[5:0] == 6'h00 && i_lock[0] && !i_par_err[0]) [*6]
         |-> o_qualified[0];
   endproperty
   a_thr0: assert property (p_thr0)
      else $error("not qualified on lock at threshold zero");
   property p_rd_hold;
      !i_reg_rd |=> $stable(o_reg_rdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data moved without a read");
   property p_unmapped;
      i_reg_rd && !(i_reg_addr inside {8'h4C, 8'h7C, 8'h7D})
         |=> o_reg_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_discard;
      (qc0[7] && !o_qualified[0]) [*4] |-> !o_fwd_vld[0];
   endproperty
   a_discard: assert property (p_discard)
      else $error("forwarded while unqualified");
   property p_pack;
      o_fwd_vld[0] && $past(cc0[7:6]) == 2'h3
         |-> o_fwd_pix[9:0] == {2'h0, $past(i_pix[7:0], 3)};
   endproperty
   a_pack: assert property (p_pack)
      else $error("lower byte packing wrong");
   property p_par_drop;
      o_qualified[0] && i_par_err[0] && !qc0[3] |-> ##[1:5] !o_qualified[0];
   endproperty
   a_par_drop: assert property (p_par_drop)
      else $error("parity error kept qualified");
   property p_trunc;
      cc0[5] && i_par_err[0] |-> ##[4:6] (!o_fwd_vld[0]) [*3];
   endproperty
   a_trunc: assert property (p_trunc)
      else $error("frame not truncated on parity error");
endmodule : rfq_asserts

bind rfq_top rfq_asserts u_chk (.i_sys_clk, .i_rst_n, .i_reg_wr, .i_reg_rd,
   .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_lock, .i_pix, .i_par_err,
   .o_qualified, .o_fwd_vld, .o_fwd_pix);

// ==== dv/rfq_src_model.sv ====
// rfq_src_model: remote serializer stand-in sending raw video frames.
// assumes: bench clock; frame shape and fault injection set by the bench.
module rfq_src_model
(
   input  wire logic       i_clk,
   input  wire logic       i_run,
   input  wire logic       i_pol,
   input  wire logic [31:0] i_lines,
   input  wire logic [31:0] i_npix,
   input  wire logic       i_bad,
   output logic            o_fv,
   output logic            o_lv,
   output logic            o_pvld,
   output logic            o_perr,
   output logic [9:0]      o_pix
);
   timeunit 1ns;
   timeprecision 1ps;
   int   c = 0;
   int   w, nl, np;
   logic f, l;
   initial {o_fv, o_lv, o_pvld, o_perr, o_pix} = '0;
   // frame shape is taken only at a frame boundary, as a real source does
   always @(negedge i_clk)
   begin
      if (c == 0)
      begin
         nl = int'(i_lines);
         np = int'(i_npix);
      end
      w = np + 2;
      f = i_run && c < nl * w;
      l = f && c % w < np;
      o_fv   <= f ^ i_pol;
      o_lv   <= l ^ i_pol;
      o_pvld <= l;
      // idle data toggles so a stale pixel is never mistaken for a good one
      o_pix  <= l ? 10'(c * 37 + 5) : ~o_pix;
      o_perr <= i_bad && c == 1;
      c      <= (!i_run || c >= nl * w + 3) ? 0 : c + 1;
   end
endmodule : rfq_src_model

// ==== dv/testbench.sv ====
// testbench: register and video scenarios for the frame qualifier.
// assumes: port 0 carries the checked traffic, port 1 runs alongside.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
   logic        run = 1'b0, pol = 1'b0;
   logic [7:0]  addr = 8'h00, wd = 8'h00, rdata;
   logic [1:0]  lock = 2'h0, bad = 2'h0, fv, lv, pv, pe, qual, fvld;
   logic [19:0] pix, fpix;
   logic [7:0]  pk [3] = '{8'h03, 8'h83, 8'hC3};
   logic [9:0]  pd [3];
   int          lines = 4, npix = 8, err_count = 0, checks_done = 0;
   always #2.5 clk = ~clk;
   for (genvar g = 0; g < 2; g++)
   begin : g_src
      rfq_src_model m (.i_clk(clk), .i_run(run), .i_pol(pol),
         .i_lines(lines), .i_npix(npix), .i_bad(bad[g]), .o_fv(fv[g]),
         .o_lv(lv[g]), .o_pvld(pv[g]), .o_perr(pe[g]),
         .o_pix(pix[g*10 +: 10]));
   end
   rfq_top dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_reg_wr(wr),
      .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wd),
      .o_reg_rdata(rdata), .i_lock(lock), .i_frame_active_flag(fv),
      .i_line_active_flag(lv), .i_pix_vld(pv), .i_pix(pix),
      .i_par_err(pe), .o_qualified(qual), .o_fwd_vld(fvld),
      .o_fwd_pix(fpix));
   ////////////////////////////////////////////////////////////////////////////
   // port-0 pixel as it stood one, two and three edges back, for packing checks
   always @(posedge clk)
   begin
      pd[0] <= pix[9:0];
      pd[1] <= pd[0];
      pd[2] <= pd[1];
   end
   function automatic logic [9:0] packed_pix(input logic [1:0] m,
                                             input logic [9:0] v);
      if (m == rfq_pkg::PACK_UPPER)
         return {2'h0, v[9:2]};
      else if (m == rfq_pkg::PACK_LOWER)
         return {2'h0, v[7:0]};
      else
         return v;
   endfunction : packed_pix
   task wrap_up;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   task chk(input logic [9:0] got, input logic [9:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task wreg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      {wr, addr, wd} = {1'b1, a, d};
      @(negedge clk);
      wr = 1'b0;
   endtask : wreg
   task rreg(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      {rd, addr} = {1'b1, a};
      @(negedge clk);
      rd = 1'b0;
      @(negedge clk);
      chk({2'h0, rdata}, {2'h0, e});
   endtask : rreg
   // hold=1: flag must stay at v for n cycles; hold=0: reach v within n
   task flag(input bit s, input logic v, input int n, input bit hold);
      logic f;
      int   k;
      for (k = 0; k < n; k++)
      begin
         @(negedge clk);
         f = s ? fvld[0] : qual[0];
         if ((f !== v) == hold)
            break;
      end
      chk({9'h000, f}, {9'h000, v});
      if (!hold && k == n)
         wrap_up();
   endtask : flag
   initial
   begin
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      rreg(8'h7C, 8'h20);
      rreg(8'h7D, 8'h00);
      rreg(8'h4C, 8'h00);
      wreg(8'h4C, 8'h02);
      wreg(8'h7D, 8'h5A);
      wreg(8'h4C, 8'h01);
      rreg(8'h7D, 8'h00);
      wreg(8'h7C, 8'hDB);
      rreg(8'h7C, 8'hDB);
      wreg(8'h70, 8'h2A);
      rreg(8'h70, 8'h00);
      wreg(8'h4C, 8'h02);
      rreg(8'h7D, 8'h5A);
      wreg(8'h7D, 8'h00);
      wreg(8'h4C, 8'h01);
      wreg(8'h7C, 8'h20);
      $display("done: registers");
      run = 1'b1;
      lock = 2'h3;
      flag(0, 1'b1, 20, 0);
      chk({8'h00, qual}, 10'h003);
      lock = 2'h0;
      flag(0, 1'b0, 10, 0);
      flag(0, 1'b0, 60, 1);
      $display("done: lock");
      pol = 1'b1;
      wreg(8'h7C, 8'h23);
      wreg(8'h7D, 8'h02);
      lock = 2'h3;
      flag(0, 1'b0, 30, 1);
      flag(0, 1'b1, 200, 0);
      $display("done: threshold");
      wreg(8'h7D, 8'h0A);
      bad[0] = 1'b1;
      flag(0, 1'b0, 60, 0);
      bad[0] = 1'b0;
      flag(0, 1'b0, 30, 1);
      flag(0, 1'b1, 150, 0);
      wreg(8'h7D, 8'h00);
      bad[0] = 1'b1;
      flag(0, 1'b0, 60, 0);
      bad[0] = 1'b0;
      flag(0, 1'b1, 10, 0);
      $display("done: parity");
      wreg(8'h7C, 8'h3B);
      for (int i = 0; i < 2; i++)
      begin
         wreg(8'h7D, i ? 8'h12 : 8'h22);
         flag(0, 1'b1, 150, 0);
         if (i)
            npix = 9;
         else
            lines = 5;
         flag(0, 1'b0, 150, 0);
      end
      lines = 4;
      npix = 8;
      $display("done: size changes");
      wreg(8'h7D, 8'h06);
      flag(0, 1'b1, 250, 0);
      run = 1'b0;
      flag(0, 1'b1, 200, 1);
      wreg(8'h7D, 8'h02);
      flag(0, 1'b0, 200, 0);
      $display("done: watchdog");
      run = 1'b1;
      lock = 2'h0;
      flag(0, 1'b0, 10, 0);
      wreg(8'h7D, 8'h82);
      flag(1, 1'b0, 150, 1);
      wreg(8'h7D, 8'h02);
      flag(1, 1'b1, 100, 0);
      for (int i = 0; i < 3; i++)
      begin
         wreg(8'h7C, pk[i]);
         flag(1, 1'b1, 100, 0);
         for (int j = 0; j < 8; j++)
         begin
            if (fvld[0])
               chk(fpix[9:0], packed_pix(pk[i][7:6], pd[2]));
            @(negedge clk);
         end
      end
      $display("done: forwarding");
      wrap_up();
   end
endmodule : testbench
